// ### hdl/dacctl_pkg.sv
package dacctl_pkg;
  // Register indices as printed; byte address is four times the index
  localparam logic [7:0] DACCTL_IDX_CONTROL = 8'h00;      // converter_control
  localparam logic [7:0] DACCTL_IDX_CODE    = 8'h01;      // converter_code
  localparam int         DACCTL_ADDR_W      = 4;          // Byte address bits decoded
  localparam logic [3:0] DACCTL_ADDR_CONTROL = 4'h0;      // Index 0 times four
  localparam logic [3:0] DACCTL_ADDR_CODE    = 4'h4;      // Index 1 times four
  // Field positions of converter_control
  localparam int         DACCTL_BIT_ENABLE  = 0;          // Converter enable
  localparam int         DACCTL_BIT_PIN     = 6;          // pin_drive_on
  localparam int         DACCTL_BIT_STBY    = 7;          // standby_run
  localparam logic [7:0] DACCTL_CTRL_MASK   = 8'hC1;      // Writable bits
  localparam logic [7:0] DACCTL_CTRL_RESET  = 8'h00;      // Reset values
  localparam logic [7:0] DACCTL_CODE_RESET  = 8'h00;
  // Start-up delay after wake from a standby or power-down stop
  localparam int         DACCTL_CLK_MHZ     = 125;        // aclk rate
  localparam int         DACCTL_STARTUP_NS  = 1000;       // Least settle time
  localparam int         DACCTL_STARTUP_CYC =
    (DACCTL_STARTUP_NS * DACCTL_CLK_MHZ + 999) / 1000;    // Rounded up
  localparam logic [1:0] DACCTL_RESP_OKAY   = 2'h0;       // AXI OKAY
  localparam logic [1:0] DACCTL_RESP_SLVERR = 2'h2;       // AXI SLVERR
  // Sleep mode encoding from the power manager
  typedef enum logic [1:0] {
    DACCTL_SLP_ACTIVE,
    DACCTL_SLP_IDLE,
    DACCTL_SLP_STANDBY,
    DACCTL_SLP_PDOWN
  } dacctl_sleep_t;
endpackage

// ### hdl/dacctl_regs.sv
// AXI4-Lite slave holding the two registers; one write, one read at a time
module dacctl_regs
  import dacctl_pkg::*;
(
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire logic [DACCTL_ADDR_W-1:0] awaddr,
  input  wire logic                     awvalid,
  output logic                          awready,
  input  wire logic [31:0]              wdata,
  input  wire logic [3:0]               wstrb,
  input  wire logic                     wvalid,
  output logic                          wready,
  output logic [1:0]                    bresp,
  output logic                          bvalid,
  input  wire logic                     bready,
  input  wire logic [DACCTL_ADDR_W-1:0] araddr,
  input  wire logic                     arvalid,
  output logic                          arready,
  output logic [31:0]                   rdata,
  output logic [1:0]                    rresp,
  output logic                          rvalid,
  input  wire logic                     rready,
  output logic [7:0]                    ctrl_q,
  output logic [7:0]                    code_q,
  output logic                          code_wr,
  output logic                          ctrl_wr
);
  // All slave state in one struct
  typedef struct packed {
    logic                     aw_have;
    logic [DACCTL_ADDR_W-1:0] aw_addr;
    logic                     w_have;
    logic [7:0]               w_data;
    logic                     w_strb0;
    logic                     bvalid;
    logic [1:0]               bresp;
    logic                     rvalid;
    logic [31:0]              rdata;
    logic [1:0]               rresp;
    logic [7:0]               ctrl;
    logic [7:0]               code;
    logic                     code_wr;
    logic                     ctrl_wr;
    logic                     aw_rdy;      // Registered awready
    logic                     w_rdy;       // Registered wready
    logic                     ar_rdy;      // Registered arready
  } dacctl_regs_t;

  dacctl_regs_t s_q, s_d;   // Registered and next state

  // Ready only while the slot is empty and no response pending
  assign awready = s_q.aw_rdy;
  assign wready  = s_q.w_rdy;
  assign arready = s_q.ar_rdy;
  assign bvalid  = s_q.bvalid;
  assign bresp   = s_q.bresp;
  assign rvalid  = s_q.rvalid;
  assign rdata   = s_q.rdata;
  assign rresp   = s_q.rresp;
  assign ctrl_q  = s_q.ctrl;
  assign code_q  = s_q.code;
  assign code_wr = s_q.code_wr;
  assign ctrl_wr = s_q.ctrl_wr;

  // Accept address and data in either order, commit once both are in
  always_comb begin
    s_d = s_q;
    s_d.code_wr = 1'b0;
    s_d.ctrl_wr = 1'b0;
    if (awvalid && awready) begin
      s_d.aw_have = 1'b1;
      s_d.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      s_d.w_have  = 1'b1;
      s_d.w_data  = wdata[7:0];
      s_d.w_strb0 = wstrb[0];
    end
    // Commit write; only lane 0 carries register data
    if (s_q.aw_have && s_q.w_have) begin
      s_d.aw_have = 1'b0;
      s_d.w_have  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = DACCTL_RESP_OKAY;
      if (s_q.aw_addr == DACCTL_ADDR_CONTROL) begin
        if (s_q.w_strb0) begin
          s_d.ctrl    = s_q.w_data & DACCTL_CTRL_MASK;
          s_d.ctrl_wr = 1'b1;
        end
      end else if (s_q.aw_addr == DACCTL_ADDR_CODE) begin
        if (s_q.w_strb0) begin
          s_d.code    = s_q.w_data;
          s_d.code_wr = 1'b1;
        end
      end else begin
        s_d.bresp = DACCTL_RESP_SLVERR;   // Unmapped address
      end
    end
    if (s_q.bvalid && bready) begin
      s_d.bvalid = 1'b0;
    end
    // Read: answer one cycle after the address is taken
    if (s_q.rvalid && rready) begin
      s_d.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = DACCTL_RESP_OKAY;
      s_d.rdata  = 32'h0000_0000;
      if (araddr == DACCTL_ADDR_CONTROL) begin
        s_d.rdata[7:0] = s_q.ctrl;
      end else if (araddr == DACCTL_ADDR_CODE) begin
        s_d.rdata[7:0] = s_q.code;
      end else begin
        s_d.rresp = DACCTL_RESP_SLVERR;
      end
    end
    // Readies from flops; low in reset, high from the first edge after it
    s_d.aw_rdy = !s_d.aw_have && !s_d.bvalid;
    s_d.w_rdy  = !s_d.w_have && !s_d.bvalid;
    s_d.ar_rdy = !s_d.rvalid;
  end

  // Synchronous reset to defined values
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q      <= '0;
      s_q.ctrl <= DACCTL_CTRL_RESET;
      s_q.code <= DACCTL_CODE_RESET;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// ### hdl/dacctl_top.sv
// Chosen here: the AXI4-Lite slave port.
module dacctl_top
  import dacctl_pkg::*;
#(
  parameter int INSTANCE = 0                              // Only zero has a pin buffer
)(
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire logic [DACCTL_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [DACCTL_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  input  wire logic [1:0]               sleep_mode,
  input  wire logic                     debug_halt,
  output logic [7:0]                    core_code,
  output logic                          core_power,
  output logic                          conv_start,
  output logic                          buffer_on,
  output logic                          internal_out_valid
);
  localparam int CNT_W = $clog2(DACCTL_STARTUP_CYC + 1);  // Delay counter width
  localparam logic [CNT_W-1:0] STARTUP_LOAD = CNT_W'(DACCTL_STARTUP_CYC);
  localparam logic HAS_PIN = (INSTANCE == 0);             // Pin buffer present

  // Whole state of the control path
  typedef struct packed {
    logic             en_prev;     // Enable seen last cycle
    logic             stopped;     // Stopped by standby or power-down
    logic             pend;        // Start owed after settle
    logic [CNT_W-1:0] cnt;         // Start-up countdown
    logic [7:0]       code;        // Code shown to core
    logic             power;
    logic             start;
    logic             buf_on;
    logic             int_ok;
  } dacctl_state_t;

  dacctl_state_t s_q, s_d;
  logic [7:0]    ctrl;            // converter_control contents
  logic [7:0]    code;            // converter_code contents
  logic          code_wr;         // One-cycle code write
  logic          ctrl_wr;         // One-cycle control write
  logic          enable;
  logic          pin_drive_on;
  logic          standby_run;
  logic          halt_run;        // Sleep stops the core
  logic          start_evt;       // A start is requested

  // Register file over AXI4-Lite, control at 0x00, code at 0x04
  dacctl_regs u_regs (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .ctrl_q  (ctrl),
    .code_q  (code),
    .code_wr (code_wr),
    .ctrl_wr (ctrl_wr)
  );

  // Field decode
  assign enable       = ctrl[DACCTL_BIT_ENABLE];
  assign pin_drive_on = ctrl[DACCTL_BIT_PIN];
  assign standby_run  = ctrl[DACCTL_BIT_STBY];

  // Power-down always stops; standby stops unless standby_run
  always_comb begin
    halt_run = 1'b0;
    case (dacctl_sleep_t'(sleep_mode))
      DACCTL_SLP_STANDBY: halt_run = !standby_run;
      DACCTL_SLP_PDOWN:   halt_run = 1'b1;
      default:            halt_run = 1'b0;
    endcase
  end

  // Write while enabled, or enable rising; debug_halt is ignored on purpose
  assign start_evt = (code_wr && enable)
                   || (enable && !s_q.en_prev);

  // Next state of the control path
  always_comb begin
    s_d         = s_q;
    s_d.en_prev = enable;
    s_d.start   = 1'b0;
    s_d.code    = code;
    if (!enable) begin
      s_d.pend    = 1'b0;
      s_d.stopped = 1'b0;
      s_d.cnt     = '0;
    end else if (halt_run) begin
      s_d.stopped = 1'b1;
      s_d.pend    = 1'b0;
      s_d.cnt     = '0;
    end else if (s_q.stopped) begin
      // Waking: power back up, wait before converting
      s_d.stopped = 1'b0;
      s_d.pend    = 1'b1;
      s_d.cnt     = STARTUP_LOAD;
    end else if (s_q.pend) begin
      if (s_q.cnt > CNT_W'(1)) begin
        s_d.cnt = s_q.cnt - CNT_W'(1);
      end else begin
        s_d.cnt   = '0;
        s_d.pend  = 1'b0;
        s_d.start = 1'b1;
      end
    end else begin
      s_d.start = start_evt;
    end
    s_d.power  = enable && !halt_run;
    s_d.int_ok = enable && !halt_run;
    s_d.buf_on = HAS_PIN && enable && pin_drive_on
                 && !halt_run;
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flip-flops
  assign core_code          = s_q.code;
  assign core_power         = s_q.power;
  assign conv_start         = s_q.start;
  assign buffer_on          = s_q.buf_on;
  assign internal_out_valid = s_q.int_ok;

  // Code write while enabled and running strobes next cycle
  sequence code_write_s;
    code_wr && enable && !halt_run && !s_q.pend && !s_q.stopped;
  endsequence
  start_on_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    code_write_s |=> conv_start)
    else $error("code write while enabled gave no start");
  no_start_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !enable |=> !conv_start)
    else $error("start while disabled");
  start_on_enable_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(enable) && !halt_run |=> conv_start && core_code == $past(code))
    else $error("enable edge gave no start");
  power_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !halt_run |=> core_power == $past(enable))
    else $error("core power not following enable");
  pin_only_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !HAS_PIN |-> !buffer_on)
    else $error("pin buffer on in other instance");
  buffer_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
    enable && pin_drive_on && !halt_run |=> buffer_on == HAS_PIN)
    else $error("buffer not following pin drive");
  internal_on_a: assert property (@(posedge aclk) disable iff (!aresetn)
    enable && !halt_run |=> internal_out_valid)
    else $error("internal output missing while enabled");
  standby_run_a: assert property (@(posedge aclk) disable iff (!aresetn)
    enable && standby_run && sleep_mode == DACCTL_SLP_STANDBY |=> core_power)
    else $error("standby_run did not keep converter on");
  standby_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    sleep_mode == DACCTL_SLP_STANDBY && !standby_run |=> !core_power && !buffer_on)
    else $error("standby did not stop converter");
  pdown_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    sleep_mode == DACCTL_SLP_PDOWN |=> !core_power && !buffer_on && !conv_start)
    else $error("power-down left converter on");
  wake_delay_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_q.stopped && enable && !halt_run |=> !conv_start)
    else $error("start without start-up delay");
  strobe_one_a: assert property (@(posedge aclk) disable iff (!aresetn)
    conv_start && !$rose(enable) && !code_wr |=> !conv_start)
    else $error("start strobe longer than one cycle");
  code_held_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $stable(code) |=> core_code == $past(code))
    else $error("core code not following register");

  // Wake from a standby or power-down stop: core back on, countdown loaded
  sequence wake_s;
    s_q.stopped && enable && !halt_run;
  endsequence
  // Countdown still running while awake and enabled
  sequence settling_s;
    s_q.pend && s_q.cnt > CNT_W'(1) && enable && !halt_run;
  endsequence
  // Last count of the wake delay, the owed start is due
  sequence settled_s;
    s_q.pend && s_q.cnt <= CNT_W'(1) && enable && !halt_run;
  endsequence

  // Enable moves only through a control write
  enable_by_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(enable) |-> ctrl_wr)
    else $error("enable changed without a control write");
  // Code moves only through a code write
  code_by_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(code) |-> code_wr)
    else $error("code changed without a code write");
  // Unused control bits always read zero
  ctrl_unused_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctrl & ~DACCTL_CTRL_MASK) == 8'h00)
    else $error("unused control bit set");
  // Power only ever follows an enable
  power_cause_a: assert property (@(posedge aclk) disable iff (!aresetn)
    core_power |-> $past(enable))
    else $error("core powered without enable");
  // Idle sleep does not stop the converter
  idle_runs_a: assert property (@(posedge aclk) disable iff (!aresetn)
    enable && sleep_mode == DACCTL_SLP_IDLE |=> core_power)
    else $error("idle sleep stopped the converter");
  // Internal taps drop with enable
  internal_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !enable |=> !internal_out_valid)
    else $error("internal output left on while disabled");
  // Internal taps fed whenever the core runs
  internal_power_a: assert property (@(posedge aclk) disable iff (!aresetn)
    core_power |-> internal_out_valid)
    else $error("core on but internal output off");
  // Buffer off without pin drive
  buffer_pin_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !pin_drive_on |=> !buffer_on)
    else $error("buffer on without pin drive");
  // Buffer never runs ahead of the core
  buffer_power_a: assert property (@(posedge aclk) disable iff (!aresetn)
    buffer_on |-> core_power)
    else $error("buffer on while core off");
  // A start is only sent to a powered core
  start_power_a: assert property (@(posedge aclk) disable iff (!aresetn)
    conv_start |-> core_power)
    else $error("start sent to an unpowered core");
  // Any stopping sleep suppresses starts
  no_start_halt_a: assert property (@(posedge aclk) disable iff (!aresetn)
    halt_run |=> !conv_start)
    else $error("start while stopped by sleep");
  // Power-down also cuts the internal taps
  pdown_internal_a: assert property (@(posedge aclk) disable iff (!aresetn)
    sleep_mode == DACCTL_SLP_PDOWN |=> !internal_out_valid)
    else $error("internal output on in power-down");
  // standby_run keeps the buffer on when pin drive is set
  stby_buffer_a: assert property (@(posedge aclk) disable iff (!aresetn)
    enable && standby_run && pin_drive_on && sleep_mode == DACCTL_SLP_STANDBY
    |=> buffer_on == HAS_PIN)
    else $error("standby_run did not keep the buffer on");
  // standby_run keeps the internal taps fed
  stby_internal_a: assert property (@(posedge aclk) disable iff (!aresetn)
    enable && standby_run && sleep_mode == DACCTL_SLP_STANDBY |=> internal_out_valid)
    else $error("standby_run did not keep internal output");
  // Debug halt must not block a code write start
  debug_blind_a: assert property (@(posedge aclk) disable iff (!aresetn)
    debug_halt ##0 code_write_s |=> conv_start)
    else $error("debug halt blocked a start");
  // Wake powers the core at once
  wake_power_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wake_s |=> core_power && internal_out_valid)
    else $error("wake did not power the core");
  // Wake brings the buffer back when pin drive is set
  wake_buffer_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_q.stopped && enable && !halt_run && pin_drive_on |=> buffer_on == HAS_PIN)
    else $error("wake did not restore the buffer");
  // No start while the wake delay runs
  settling_a: assert property (@(posedge aclk) disable iff (!aresetn)
    settling_s |=> !conv_start)
    else $error("start inside the wake delay");
  // Owed start fires with the latest code
  settled_a: assert property (@(posedge aclk) disable iff (!aresetn)
    settled_s |=> conv_start && core_code == $past(code))
    else $error("no start at the end of the wake delay");
  // Enable while asleep defers the start to the wake
  halt_enable_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(enable) && halt_run |=> !conv_start && s_q.stopped)
    else $error("enable while asleep not deferred");
endmodule

// ### bench/dacctl_analog_model.sv
// Far-side stand-in: analog core, pin buffer and internal consumers
module dacctl_analog_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  core_code,
  input  wire logic        core_power,
  input  wire logic        conv_start,
  input  wire logic        buffer_on,
  input  wire logic        internal_out_valid,
  output logic      [7:0]  level_q,
  output logic      [15:0] starts_q,
  output logic      [7:0]  pin_level,
  output logic      [7:0]  int_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // Core settles only on a powered start; unpowered it drifts every cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      level_q  <= 8'h00;
      starts_q <= 16'h0000;
    end else if (conv_start && core_power) begin
      level_q  <= core_code;
      starts_q <= starts_q + 16'h0001;
    end else if (!core_power) begin
      level_q <= ~level_q; // No stale level survives power-off
    end
  end
  // Released taps show the inverse, so a dead path never passes by luck
  assign pin_level = buffer_on ? level_q : ~level_q;
  assign int_level = internal_out_valid ? level_q : ~level_q;
endmodule

// ### bench/test_dac_control_logic.sv
module test_dac_control_logic;
  timeunit 1ns;
  timeprecision 1ps;
  import dacctl_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, debug_halt = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, sleep_mode = 2'h0, r;
  logic [7:0] core_code, level_q, pin_level, int_level, d;
  logic core_power, conv_start, buffer_on, internal_out_valid, buf1, int1;
  logic [15:0] starts_q, s0;
  int error_cnt = 0, checks_done = 0;
  // Pin-capable instance and a second one that may only feed internal taps
  dacctl_top #(.INSTANCE(0)) DUT (.*);
  dacctl_top #(.INSTANCE(1)) DUT1 (.*, .s_axi_awready(), .s_axi_wready(), .s_axi_bresp(),
    .s_axi_bvalid(), .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(),
    .core_code(), .core_power(), .conv_start(), .buffer_on(buf1), .internal_out_valid(int1));
  dacctl_analog_model model (.aclk(aclk), .aresetn(aresetn), .core_code(core_code),
    .core_power(core_power), .conv_start(conv_start), .buffer_on(buffer_on),
    .internal_out_valid(internal_out_valid), .level_q(level_q), .starts_q(starts_q),
    .pin_level(pin_level), .int_level(int_level));
  // 125 MHz clock
  always #4 aclk = ~aclk;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Write: both channels offered at once, each dropped at its own handshake
  task automatic wr(input logic [3:0] a, input logic [7:0] v, output logic [1:0] rs);
    logic aw_t, w_t, b_t;
    int n;
    aw_t = 1'b0;
    w_t = 1'b0;
    b_t = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 200 && !b_t; n++) begin
      @(posedge aclk);
      if (!aw_t && s_axi_awready === 1'b1) aw_t = 1'b1;
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (!w_t && s_axi_wready === 1'b1) w_t = 1'b1;
      if (w_t) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) b_t = 1'b1;
    end
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    chk("write_answered", 1, b_t);
    @(posedge aclk); // Let bready settle low before any next request
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v, output logic [1:0] rs);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    v = s_axi_rdata[7:0];
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk("read_answered", 1, s_axi_rvalid);
    @(posedge aclk); // Let rready settle low before any next request
  endtask
  task automatic t_reset();
    rd(DACCTL_ADDR_CONTROL, d, r);
    chk("ctrl_reset", DACCTL_CTRL_RESET, d);
    rd(DACCTL_ADDR_CODE, d, r);
    chk("code_reset", DACCTL_CODE_RESET, d);
    chk("power_reset", 0, core_power);
    $display("reset test done");
  endtask
  // Stored but not converted while disabled
  task automatic t_disabled(input logic [7:0] v);
    s0 = starts_q;
    wr(DACCTL_ADDR_CODE, v, r);
    idle(4);
    chk("starts_off", s0, starts_q);
    chk("core_code", v, core_code);
    rd(DACCTL_ADDR_CODE, d, r);
    chk("code_read", v, d);
    $display("disabled write test done");
  endtask
  // Code set first, then enable and pin drive in one write, then pin drive dropped
  task automatic t_enable();
    s0 = starts_q;
    wr(DACCTL_ADDR_CONTROL, 8'h41, r);
    idle(4);
    chk("starts_en", s0 + 1, starts_q);
    chk("level_en", 8'hA5, level_q);
    chk("power_on", 1, core_power);
    chk("pin_level", 8'hA5, pin_level);
    chk("buf1_off", 0, buf1);
    chk("int1_on", 1, int1);
    wr(DACCTL_ADDR_CONTROL, 8'h01, r);
    idle(2);
    chk("buffer_off", 0, buffer_on);
    chk("int_level", 8'hA5, int_level);
    $display("enable test done");
  endtask
  task automatic t_b2b();
    s0 = starts_q;
    sleep_mode <= DACCTL_SLP_IDLE;
    wr(DACCTL_ADDR_CODE, 8'h00, r);
    wr(DACCTL_ADDR_CODE, 8'hFF, r);
    idle(4);
    chk("starts_b2b", s0 + 2, starts_q);
    chk("level_b2b", 8'hFF, level_q);
    chk("idle_power", 1, core_power);
    sleep_mode <= DACCTL_SLP_ACTIVE;
    $display("back to back test done");
  endtask
  // Unused bits, then standby with run set and debug halt raised
  task automatic t_stby_run();
    wr(DACCTL_ADDR_CONTROL, 8'hFF, r);
    rd(DACCTL_ADDR_CONTROL, d, r);
    chk("ctrl_mask", 8'hC1, d);
    sleep_mode <= DACCTL_SLP_STANDBY;
    debug_halt <= 1'b1;
    idle(8);
    chk("stby_power", 1, core_power);
    chk("stby_buffer", 1, buffer_on);
    s0 = starts_q;
    wr(DACCTL_ADDR_CODE, 8'h3C, r);
    idle(4);
    chk("stby_level", 8'h3C, level_q);
    sleep_mode <= DACCTL_SLP_ACTIVE;
    debug_halt <= 1'b0;
    $display("standby run test done");
  endtask
  task automatic t_unmapped();
    s0 = starts_q;
    wr(4'h8, 8'h00, r);
    chk("wr_slverr", DACCTL_RESP_SLVERR, r);
    rd(4'h8, d, r);
    chk("rd_slverr", DACCTL_RESP_SLVERR, r);
    rd(DACCTL_ADDR_CONTROL, d, r);
    chk("ctrl_kept", 8'hC1, d);
    chk("starts_kept", s0, starts_q);
    $display("unmapped test done");
  endtask
  // Standby stop, then wake with start-up delay before the conversion
  task automatic t_stby_stop();
    int n;
    wr(DACCTL_ADDR_CONTROL, 8'h41, r);
    sleep_mode <= DACCTL_SLP_STANDBY;
    idle(4);
    chk("stop_power", 0, core_power);
    chk("stop_buffer", 0, buffer_on);
    s0 = starts_q;
    sleep_mode <= DACCTL_SLP_ACTIVE;
    for (n = 0; n < 300 && starts_q === s0; n++) idle(1);
    chk("wake_delay", 1, n >= DACCTL_STARTUP_CYC - 2 && n <= DACCTL_STARTUP_CYC + 4);
    chk("wake_power", 1, core_power);
    chk("wake_buffer", 1, buffer_on);
    $display("standby stop test done");
  endtask
  task automatic t_pdown();
    wr(DACCTL_ADDR_CONTROL, 8'hC1, r);
    sleep_mode <= DACCTL_SLP_PDOWN;
    idle(4);
    chk("pd_power", 0, core_power);
    chk("pd_buffer", 0, buffer_on);
    sleep_mode <= DACCTL_SLP_ACTIVE;
    idle(DACCTL_STARTUP_CYC + 10);
    $display("power-down test done");
  endtask
  task automatic t_disable();
    wr(DACCTL_ADDR_CONTROL, 8'h00, r);
    idle(4);
    chk("dis_power", 0, core_power);
    chk("dis_internal", 0, internal_out_valid);
    t_disabled(8'h77);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Whole run needs well under 3000 cycles
  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    report_and_stop();
  end
  initial begin
    idle(16);
    aresetn <= 1'b1;
    idle(1);
    t_reset();
    t_disabled(8'hA5);
    t_enable();
    t_b2b();
    t_stby_run();
    t_unmapped();
    t_stby_stop();
    t_pdown();
    t_disable();
    report_and_stop();
  end
endmodule
